// ===== supervisor_pkg.sv
// Shared constants and types for the dual supply reset supervisor
package supervisor_pkg;

   // ***********************************************
   // Timebase
   // ***********************************************
   localparam int unsigned CLK_MHZ        = 40;             // Cycles per microsecond
   localparam int unsigned CYC_PER_MS     = CLK_MHZ * 1000;
   localparam int unsigned BTN_QUAL_US    = 20;             // Least button low time
   localparam int unsigned BTN_QUAL_CYC   = BTN_QUAL_US * CLK_MHZ;
   localparam int unsigned ALERT_FILT_NS  = 2000;           // Sense low filter time
   localparam int unsigned ALERT_FILT_CYC = ALERT_FILT_NS * CLK_MHZ / 1000;
   localparam int unsigned ALERT_PULSE_US = 10;             // Least alert pulse
   localparam int unsigned ALERT_PULSE_CYC = ALERT_PULSE_US * CLK_MHZ;
   localparam int unsigned WD_PULSE_US    = 100;            // Least watchdog pulse
   localparam int unsigned WD_PULSE_CYC   = WD_PULSE_US * CLK_MHZ;
   localparam int unsigned TD_GND_TYP_MS   = 16;            // Delay strap grounded
   localparam int unsigned TD_FLOAT_TYP_MS = 160;           // Delay strap floating
   localparam int unsigned TD_HIGH_TYP_MS  = 1600;          // Delay strap tied high

   // ***********************************************
   // Counter widths
   // ***********************************************
   localparam int unsigned DLY_W  = 27;
   localparam int unsigned QUAL_W = 10;
   localparam int unsigned AF_W   = 7;
   localparam int unsigned AP_W   = 9;
   localparam int unsigned WP_W   = 12;

   // ***********************************************
   // Strap codes and tolerance windows
   // ***********************************************
   localparam logic [1:0] STRAP_FLOAT = 2'h0;
   localparam logic [1:0] STRAP_LOW   = 2'h1;
   localparam logic [1:0] STRAP_HIGH  = 2'h2;
   localparam logic [4:0] TOL_PCT_TIED  = 5'h05;
   localparam logic [4:0] TOL_PCT_GND   = 5'h0a;
   localparam logic [4:0] TOL_HI_FLOAT  = 5'h0f;
   localparam logic [4:0] TOL_LO_FLOAT  = 5'h14;

   typedef enum {VAR_BASE, VAR_WATCHDOG, VAR_STATUS} variant_t;

   // Three-level strap as sensed by the pin front end
   typedef struct packed {
      logic tied_high;
      logic tied_low;
   } strap_pins_t;

   // All pin inputs sampled together by the synchroniser
   typedef struct packed {
      logic [1:0]        in_tol;    // 0 high supply, 1 low supply
      logic [1:0]        btn_n;
      logic              master_n;
      logic [1:0]        sense_low;
      logic              strobe;
      strap_pins_t [1:0] tol;
      strap_pins_t [2:0] dly;       // 0 high, 1 low, 2 watchdog
   } pin_sample_t;

endpackage

// ===== reset_supervisor.sv
// Dual supply reset supervisor control logic
`timescale 1ns/100ps
// What this block does
// - Supply out of tolerance drives its reset low
// - Recovered supply keeps reset for selected delay
// - Power-up holds resets until tolerance plus delay
// - High supply strap picks 5, 10, 15 percent
// - Low supply strap picks 5, 10, 20 percent
// - Tolerance straps captured once at power-up
// - Delay strap picks 16, 160, 1600 ms
// - Separate delay straps per reset and watchdog
// - Delay straps freeze once in tolerance
// - Button low 20 us requests supply reset
// - Held button holds reset, then full delay
// - Master starts only with supply ok, output active
// - Master forces all outputs, then their delays
// - Master button debounced on press and release
// - Variant parameter swaps watchdog or status features
// - Watchdog counts only once a reset released
// - Any strobe edge restarts watchdog count
// - Watchdog expiry pulses status at least 100 us
// - Alert after 2 us below, pulses 10 us
module reset_supervisor
   import supervisor_pkg::*;
#(
   parameter variant_t    VARIANT     = VAR_BASE,
   parameter int unsigned DLY_GND_CYC = TD_GND_TYP_MS * CYC_PER_MS,
   parameter int unsigned DLY_FLT_CYC = TD_FLOAT_TYP_MS * CYC_PER_MS,
   parameter int unsigned DLY_HI_CYC  = TD_HIGH_TYP_MS * CYC_PER_MS
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        high_supply_in_tol,
   input  wire logic        low_supply_in_tol,
   input  wire strap_pins_t high_supply_tolerance_strap,
   input  wire strap_pins_t low_supply_tolerance_strap,
   input  wire strap_pins_t high_supply_delay_strap,
   input  wire strap_pins_t low_supply_delay_strap,
   input  wire strap_pins_t watchdog_delay_strap,
   input  wire logic        high_supply_button_n,
   input  wire logic        low_supply_button_n,
   input  wire logic        all_outputs_button_n,
   input  wire logic        sense_input_a,
   input  wire logic        sense_input_b,
   input  wire logic        watchdog_strobe,
   output logic [4:0]       high_supply_tol_pct,
   output logic [4:0]       low_supply_tol_pct,
   output logic             high_supply_reset_n,
   output logic             high_supply_reset_oe_n,
   output logic             low_supply_reset_n,
   output logic             low_supply_reset_oe_n,
   output logic             threshold_alert_a_n,
   output logic             threshold_alert_a_oe_n,
   output logic             threshold_alert_b_n,
   output logic             threshold_alert_b_oe_n,
   output logic             watchdog_expired_n,
   output logic             watchdog_expired_oe_n,
   output logic             last_reset_source_n,
   output logic             last_reset_source_oe_n
);

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      pin_sample_t              s1;
      pin_sample_t              s2;
      logic                     strobe_s3;
      logic [1:0]               init;
      logic                     tol_done;
      logic                     dly_frozen;
      logic [1:0][1:0]          tol_code;
      logic [2:0][1:0]          dly_code;
      logic [1:0][QUAL_W-1:0]   bq_cnt;
      logic [1:0]               bq_ok;
      logic [QUAL_W-1:0]        mq_cnt;
      logic                     mq_hold;
      logic [1:0][DLY_W-1:0]    rd_cnt;
      logic [1:0]               rst_act;
      logic [1:0][AF_W-1:0]     af_cnt;
      logic [1:0][AP_W-1:0]     ap_cnt;
      logic [1:0]               a_act;
      logic [1:0]               a_armed;
      logic [DLY_W-1:0]         wd_cnt;
      logic [WP_W-1:0]          wp_cnt;
      logic                     wd_act;
      logic                     last_master;
   } state_t;

   state_t      st_reg;
   state_t      st_next;
   pin_sample_t pins;
   logic [1:0]  hold;
   logic [1:0]  btn_live;
   logic        any_active;
   logic        start_ok;
   logic        strobe_edge;

   // Three-level strap to code; both sensed at once counts as floating
   function automatic logic [1:0] strap_code(input strap_pins_t s);
      if (s.tied_high && !s.tied_low) begin
         return STRAP_HIGH;
      end else if (s.tied_low && !s.tied_high) begin
         return STRAP_LOW;
      end
      return STRAP_FLOAT;
   endfunction

   // Delay code to last count value of a stretch
   function automatic logic [DLY_W-1:0] delay_last(input logic [1:0] code);
      if (code == STRAP_LOW) begin
         return DLY_W'(DLY_GND_CYC - 1);
      end else if (code == STRAP_HIGH) begin
         return DLY_W'(DLY_HI_CYC - 1);
      end
      return DLY_W'(DLY_FLT_CYC - 1);
   endfunction

   // Pin inputs gathered for the synchroniser
   assign pins = '{in_tol: {low_supply_in_tol, high_supply_in_tol},
                   btn_n: {low_supply_button_n, high_supply_button_n},
                   master_n: all_outputs_button_n,
                   sense_low: {sense_input_b, sense_input_a},
                   strobe: watchdog_strobe,
                   tol: {low_supply_tolerance_strap, high_supply_tolerance_strap},
                   dly: {watchdog_delay_strap, low_supply_delay_strap,
                         high_supply_delay_strap}};

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.strobe_s3 = st_reg.s2.strobe;
      if (st_reg.init != 2'h3) begin
         st_next.init = st_reg.init + 2'h1;
      end
      // Tolerance captured once when the synchroniser is full
      if (st_reg.init == 2'h2 && !st_reg.tol_done) begin
         st_next.tol_done = 1'b1;
         for (int i = 0; i < 2; i++) begin
            st_next.tol_code[i] = strap_code(st_reg.s2.tol[i]);
         end
      end
      // Delay straps follow the pins until any supply is in tolerance
      if (st_reg.init[1] && !st_reg.dly_frozen) begin
         for (int k = 0; k < 3; k++) begin
            st_next.dly_code[k] = strap_code(st_reg.s2.dly[k]);
         end
         if (st_reg.tol_done && (|st_reg.s2.in_tol)) begin
            st_next.dly_frozen = 1'b1;
         end
      end
      any_active = (|st_reg.rst_act) || (|st_reg.a_act) || st_reg.wd_act;
      start_ok = ((|st_reg.s2.in_tol) || (|(~st_reg.s2.sense_low))) && any_active;
      // Master button debounced both ways with the qualify interval
      if (VARIANT == VAR_WATCHDOG) begin
         st_next.mq_hold = 1'b0;
         st_next.mq_cnt = '0;
      end else if (st_reg.s2.master_n == st_reg.mq_hold) begin
         if (st_reg.mq_cnt == QUAL_W'(BTN_QUAL_CYC - 1)) begin
            st_next.mq_cnt = '0;
            st_next.mq_hold = !st_reg.mq_hold;
         end else if (st_reg.mq_hold || start_ok) begin
            st_next.mq_cnt = st_reg.mq_cnt + 1'b1;
         end else begin
            st_next.mq_cnt = '0;
         end
      end else begin
         st_next.mq_cnt = '0;
      end
      // Per supply buttons, the low one is absent on the status variant
      btn_live[0] = st_reg.s2.btn_n[0];
      btn_live[1] = (VARIANT == VAR_STATUS) ? 1'b1 : st_reg.s2.btn_n[1];
      for (int i = 0; i < 2; i++) begin
         if (btn_live[i]) begin
            st_next.bq_cnt[i] = '0;
            st_next.bq_ok[i] = 1'b0;
         end else if (st_reg.bq_cnt[i] == QUAL_W'(BTN_QUAL_CYC - 1)) begin
            st_next.bq_ok[i] = 1'b1;
         end else begin
            st_next.bq_cnt[i] = st_reg.bq_cnt[i] + 1'b1;
         end
         // Reset held until delay codes freeze, so the stretch loads the strapped delay
         hold[i] = !st_reg.dly_frozen || !st_reg.s2.in_tol[i] || st_reg.bq_ok[i] ||
                   st_reg.mq_hold;
         if (hold[i]) begin
            st_next.rst_act[i] = 1'b1;
            st_next.rd_cnt[i] = delay_last(st_reg.dly_code[i]);
         end else if (st_reg.rst_act[i]) begin
            if (st_reg.rd_cnt[i] == '0) begin
               st_next.rst_act[i] = 1'b0;
            end else begin
               st_next.rd_cnt[i] = st_reg.rd_cnt[i] - 1'b1;
            end
         end
         // Threshold alert: filtered low sense, then a fixed pulse
         if (st_reg.a_act[i]) begin
            if (st_reg.ap_cnt[i] == '0) begin
               st_next.a_act[i] = 1'b0;
            end else begin
               st_next.ap_cnt[i] = st_reg.ap_cnt[i] - 1'b1;
            end
         end
         if (!st_reg.s2.sense_low[i] || (i == 1 && VARIANT == VAR_WATCHDOG)) begin
            st_next.af_cnt[i] = '0;
            st_next.a_armed[i] = 1'b1;
         end else if (st_reg.a_armed[i]) begin
            if (st_reg.af_cnt[i] == AF_W'(ALERT_FILT_CYC - 1)) begin
               st_next.af_cnt[i] = '0;
               st_next.a_armed[i] = 1'b0;
               st_next.a_act[i] = 1'b1;
               st_next.ap_cnt[i] = AP_W'(ALERT_PULSE_CYC - 1);
            end else begin
               st_next.af_cnt[i] = st_reg.af_cnt[i] + 1'b1;
            end
         end
         if (st_reg.mq_hold) begin
            st_next.a_act[i] = 1'b1;
            st_next.ap_cnt[i] = AP_W'(ALERT_PULSE_CYC - 1);
         end
      end
      // Watchdog runs once any reset is released
      strobe_edge = st_reg.s2.strobe ^ st_reg.strobe_s3;
      if (st_reg.wd_act) begin
         if (st_reg.wp_cnt == '0) begin
            st_next.wd_act = 1'b0;
         end else begin
            st_next.wp_cnt = st_reg.wp_cnt - 1'b1;
         end
      end
      if (VARIANT != VAR_WATCHDOG || (&st_reg.rst_act)) begin
         st_next.wd_cnt = '0;
      end else if (strobe_edge) begin
         st_next.wd_cnt = '0;
      end else if (st_reg.wd_cnt == delay_last(st_reg.dly_code[2])) begin
         st_next.wd_cnt = '0;
         st_next.wd_act = 1'b1;
         st_next.wp_cnt = WP_W'(WD_PULSE_CYC - 1);
      end else begin
         st_next.wd_cnt = st_reg.wd_cnt + 1'b1;
      end
      // Last reset source: master sets, other reset causes clear
      if (VARIANT == VAR_STATUS) begin
         if (st_reg.mq_hold) begin
            st_next.last_master = 1'b1;
         end else if (!(&st_reg.s2.in_tol) || (|st_reg.bq_ok)) begin
            st_next.last_master = 1'b0;
         end
      end
   end

   // State register, resets and alerts active from power-on
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
         st_reg.s1.btn_n <= 2'h3;
         st_reg.s2.btn_n <= 2'h3;
         st_reg.s1.master_n <= 1'b1;
         st_reg.s2.master_n <= 1'b1;
         st_reg.dly_code <= {3{STRAP_FLOAT}};
         st_reg.rst_act <= 2'h3;
         st_reg.a_act <= 2'h3;
         st_reg.ap_cnt <= {2{AP_W'(ALERT_PULSE_CYC - 1)}};
      end else begin
         st_reg <= st_next;
      end
   end

   // ***********************************************
   // Outputs, open-drain enables low while pulling low
   // ***********************************************
   assign high_supply_tol_pct    = (st_reg.tol_code[0] == STRAP_HIGH) ? TOL_PCT_TIED :
                                   (st_reg.tol_code[0] == STRAP_LOW) ? TOL_PCT_GND :
                                   TOL_HI_FLOAT;
   assign low_supply_tol_pct     = (st_reg.tol_code[1] == STRAP_HIGH) ? TOL_PCT_TIED :
                                   (st_reg.tol_code[1] == STRAP_LOW) ? TOL_PCT_GND :
                                   TOL_LO_FLOAT;
   assign high_supply_reset_n    = !st_reg.rst_act[0];
   assign high_supply_reset_oe_n = !st_reg.rst_act[0];
   assign low_supply_reset_n     = !st_reg.rst_act[1];
   assign low_supply_reset_oe_n  = !st_reg.rst_act[1];
   assign threshold_alert_a_n    = !st_reg.a_act[0];
   assign threshold_alert_a_oe_n = !st_reg.a_act[0];
   assign threshold_alert_b_n    = !st_reg.a_act[1];
   assign threshold_alert_b_oe_n = !st_reg.a_act[1];
   assign watchdog_expired_n     = !st_reg.wd_act;
   assign watchdog_expired_oe_n  = !st_reg.wd_act;
   assign last_reset_source_n    = !st_reg.last_master;
   assign last_reset_source_oe_n = !st_reg.last_master;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_fault_reset;
      !st_reg.s2.in_tol[0] |=> !high_supply_reset_n;
   endproperty
   a_fault_reset: assert property (p_fault_reset) else $error("fault kept reset off");

   property p_stretch_end;
      st_reg.rst_act[1] && !hold[1] && st_reg.rd_cnt[1] == '0 |=> low_supply_reset_n;
   endproperty
   a_stretch_end: assert property (p_stretch_end) else $error("stretch overran");

   property p_powerup_hold;
      !st_reg.tol_done |-> !high_supply_reset_n && !low_supply_reset_n;
   endproperty
   a_powerup_hold: assert property (p_powerup_hold) else $error("early release");

   property p_hi_tol;
      st_reg.tol_code[0] == STRAP_FLOAT |-> high_supply_tol_pct == 5'h0f;
   endproperty
   a_hi_tol: assert property (p_hi_tol) else $error("high window wrong");

   property p_lo_tol;
      st_reg.tol_code[1] == STRAP_FLOAT |-> low_supply_tol_pct == 5'h14;
   endproperty
   a_lo_tol: assert property (p_lo_tol) else $error("low window wrong");

   property p_tol_frozen;
      st_reg.tol_done |=> $stable(st_reg.tol_code) && st_reg.tol_done;
   endproperty
   a_tol_frozen: assert property (p_tol_frozen) else $error("tolerance changed");

   property p_dly_frozen;
      st_reg.dly_frozen |=> $stable(st_reg.dly_code);
   endproperty
   a_dly_frozen: assert property (p_dly_frozen) else $error("delay code changed");

   property p_button_hold;
      st_reg.bq_ok[0] |=> !high_supply_reset_n ##1 !high_supply_reset_n;
   endproperty
   a_button_hold: assert property (p_button_hold) else $error("button not held");

   property p_qual_restart;
      st_reg.s2.btn_n[0] |=> st_reg.bq_cnt[0] == '0 && !st_reg.bq_ok[0];
   endproperty
   a_qual_restart: assert property (p_qual_restart) else $error("qualify kept");

   property p_master_all;
      st_reg.mq_hold |=> !high_supply_reset_n && !low_supply_reset_n &&
                         !threshold_alert_a_n;
   endproperty
   a_master_all: assert property (p_master_all) else $error("master not forced");

   property p_strobe_restart;
      strobe_edge && !st_reg.wd_act |=> st_reg.wd_cnt == '0 && watchdog_expired_n;
   endproperty
   a_strobe_restart: assert property (p_strobe_restart) else $error("no restart");

   property p_wd_pulse;
      $rose(st_reg.wd_act) |-> st_reg.wp_cnt == WP_W'(WD_PULSE_CYC - 1);
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) else $error("short watchdog pulse");

endmodule

// ===== supervisor_partner_model.sv
// Behavioural model of the supply comparators and pushbuttons facing the supervisor
`timescale 1ns/100ps
module supervisor_partner_model (
   input  wire logic sys_clk,
   input  wire logic high_supply_reset_n,
   output logic      high_supply_in_tol,
   output logic      low_supply_in_tol,
   output logic      high_supply_button_n,
   output logic      low_supply_button_n,
   output logic      all_outputs_button_n
);
   logic chain_en;
   logic low_btn_reg;

   // ***********************************************
   // Idle state: supplies good, buttons pulled up
   // ***********************************************
   initial begin
      chain_en             = 1'b0;
      low_btn_reg          = 1'b1;
      high_supply_in_tol   = 1'b1;
      low_supply_in_tol    = 1'b1;
      high_supply_button_n = 1'b1;
      all_outputs_button_n = 1'b1;
   end

   // Chained high reset pulls the low supply button, pull-up otherwise
   assign low_supply_button_n = chain_en ? (low_btn_reg & high_supply_reset_n) : low_btn_reg;

   // Moves one pin just after a falling edge
   task automatic set_pin(input int which, input logic v);
      @(negedge sys_clk);
      case (which)
         0: high_supply_button_n = v;
         1: low_btn_reg = v;
         2: all_outputs_button_n = v;
         3: high_supply_in_tol = v;
         default: low_supply_in_tol = v;
      endcase
   endtask

   // Holds a button low for a number of cycles, then lets the pull-up win
   task automatic press(input int which, input int cycles);
      set_pin(which, 1'b0);
      repeat (cycles - 1) @(negedge sys_clk);
      set_pin(which, 1'b1);
   endtask
endmodule

// ===== dual_supply_reset_supervisor_tb.sv
// Self-checking bench for the dual supply reset supervisor
`timescale 1ns/100ps
module dual_supply_reset_supervisor_tb;
   import supervisor_pkg::*;
   localparam int D_GND = 50;
   localparam int D_FLT = 100;
   localparam int D_HI  = 200;
   logic        sys_clk, resetn, hi_ok, lo_ok, hi_btn_n, lo_btn_n, all_btn_n, sense_a;
   strap_pins_t hi_tol, lo_tol, hi_dly, lo_dly;
   logic [4:0]  hi_pct, lo_pct;
   logic        high_supply_reset_n, low_supply_reset_n, alert_a_n, alert_b_n, strobe, wd_n;
   int          miscompares, n_compared, seed, n, m, w;

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   supervisor_partner_model u_supervisor_partner_model (.sys_clk(sys_clk),
      .high_supply_reset_n(high_supply_reset_n), .high_supply_in_tol(hi_ok),
      .low_supply_in_tol(lo_ok), .high_supply_button_n(hi_btn_n),
      .low_supply_button_n(lo_btn_n), .all_outputs_button_n(all_btn_n));

   reset_supervisor #(.VARIANT(VAR_BASE), .DLY_GND_CYC(D_GND), .DLY_FLT_CYC(D_FLT),
      .DLY_HI_CYC(D_HI)) u_reset_supervisor (.sys_clk(sys_clk), .resetn(resetn),
      .high_supply_in_tol(hi_ok), .low_supply_in_tol(lo_ok),
      .high_supply_tolerance_strap(hi_tol), .low_supply_tolerance_strap(lo_tol),
      .high_supply_delay_strap(hi_dly), .low_supply_delay_strap(lo_dly),
      .watchdog_delay_strap(2'h0), .high_supply_button_n(hi_btn_n),
      .low_supply_button_n(lo_btn_n), .all_outputs_button_n(all_btn_n),
      .sense_input_a(sense_a), .sense_input_b(1'b0), .watchdog_strobe(1'b0),
      .high_supply_tol_pct(hi_pct), .low_supply_tol_pct(lo_pct),
      .high_supply_reset_n(high_supply_reset_n), .high_supply_reset_oe_n(),
      .low_supply_reset_n(low_supply_reset_n), .low_supply_reset_oe_n(),
      .threshold_alert_a_n(alert_a_n), .threshold_alert_a_oe_n(),
      .threshold_alert_b_n(alert_b_n), .threshold_alert_b_oe_n(),
      .watchdog_expired_n(), .watchdog_expired_oe_n(),
      .last_reset_source_n(), .last_reset_source_oe_n());

   // Watchdog variant on the same pins; only its expiry output is watched
   reset_supervisor #(.VARIANT(VAR_WATCHDOG), .DLY_GND_CYC(D_GND), .DLY_FLT_CYC(D_FLT),
      .DLY_HI_CYC(D_HI)) u_reset_supervisor_wd (.sys_clk(sys_clk), .resetn(resetn),
      .high_supply_in_tol(hi_ok), .low_supply_in_tol(lo_ok),
      .high_supply_tolerance_strap(hi_tol), .low_supply_tolerance_strap(lo_tol),
      .high_supply_delay_strap(hi_dly), .low_supply_delay_strap(lo_dly),
      .watchdog_delay_strap(2'h1), .high_supply_button_n(hi_btn_n),
      .low_supply_button_n(lo_btn_n), .all_outputs_button_n(all_btn_n),
      .sense_input_a(sense_a), .sense_input_b(1'b0), .watchdog_strobe(strobe),
      .high_supply_tol_pct(), .low_supply_tol_pct(), .high_supply_reset_n(),
      .high_supply_reset_oe_n(), .low_supply_reset_n(), .low_supply_reset_oe_n(),
      .threshold_alert_a_n(), .threshold_alert_a_oe_n(), .threshold_alert_b_n(),
      .threshold_alert_b_oe_n(), .watchdog_expired_n(wd_n), .watchdog_expired_oe_n(),
      .last_reset_source_n(), .last_reset_source_oe_n());

   // ***********************************************
   // Checking and closing
   // ***********************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Expected stretch window: the delay plus a few cycles of pin latency
   function automatic logic in_window(input int cnt, input int d);
      return (cnt >= d) && (cnt <= d + 12);
   endfunction

   // Counts falling edges while a reset stays low, bounded
   task automatic count_low(input int which, output int cnt);
      cnt = 0;
      while ((which == 0 ? high_supply_reset_n : low_supply_reset_n) !== 1'b1) begin
         @(negedge sys_clk);
         cnt++;
         if (cnt > 5000) begin
            miscompares++;
            test_done();
         end
      end
   endtask

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      seed = 32'h441f5d0b;
      miscompares = 0;
      n_compared = 0;
      resetn = 1'b0;
      sense_a = 1'b0;
      strobe = 1'b0;
      hi_tol = 2'h2;
      lo_tol = 2'h1;
      hi_dly = 2'h1;
      lo_dly = 2'h0;
      repeat (20) @(negedge sys_clk);
      chk("resets in power-up", {high_supply_reset_n, low_supply_reset_n}, 2'h0);
      chk("pct before capture", {hi_pct, lo_pct}, {TOL_HI_FLOAT, TOL_LO_FLOAT});
      resetn = 1'b1;
      count_low(0, n);
      chk("high first release", in_window(n, D_GND), 1'b1);
      chk("low held longer", low_supply_reset_n, 1'b0);
      count_low(1, m);
      chk("low first release", in_window(n + m, D_FLT), 1'b1);
      chk("high pct", hi_pct, TOL_PCT_TIED);
      chk("low pct", lo_pct, TOL_PCT_GND);
      hi_tol = 2'h0;
      lo_tol = 2'h0;
      hi_dly = 2'h2;
      lo_dly = 2'h2;
      repeat (10) @(negedge sys_clk);
      chk("pct after strap change", {hi_pct, lo_pct}, {TOL_PCT_TIED, TOL_PCT_GND});
      // Supply faults of random length on each supply
      for (w = 0; w < 2; w++) begin
         u_supervisor_partner_model.set_pin(3 + w, 1'b0);
         repeat (3) @(negedge sys_clk);
         chk("fault reset", w == 0 ? high_supply_reset_n : low_supply_reset_n, 1'b0);
         repeat (20 + ($unsigned($random(seed)) % 100)) @(negedge sys_clk);
         u_supervisor_partner_model.set_pin(3 + w, 1'b1);
         count_low(w, n);
         chk("fault stretch", in_window(n, w == 0 ? D_GND : D_FLT), 1'b1);
      end
      // Short press of 100 to 789 cycles, under qualification, is ignored
      u_supervisor_partner_model.press(0, 100 + ($unsigned($random(seed)) % 690));
      repeat (10) @(negedge sys_clk);
      chk("short press", high_supply_reset_n, 1'b1);
      fork
         u_supervisor_partner_model.press(0, 900);
         begin
            repeat (860) @(negedge sys_clk);
            chk("button hold", high_supply_reset_n, 1'b0);
         end
      join
      count_low(0, n);
      chk("button stretch", in_window(n, D_GND), 1'b1);
      // Master refused while every output is inactive
      u_supervisor_partner_model.press(2, 900);
      repeat (5) @(negedge sys_clk);
      chk("master refused", {high_supply_reset_n, alert_a_n}, 2'h3);
      // Master accepted with low reset active, after bounce
      u_supervisor_partner_model.set_pin(1, 1'b0);
      repeat (900) @(negedge sys_clk);
      repeat (4) u_supervisor_partner_model.press(2, 10 + ($unsigned($random(seed)) % 300));
      chk("bounce ignored", high_supply_reset_n, 1'b1);
      u_supervisor_partner_model.set_pin(2, 1'b0);
      repeat (850) @(negedge sys_clk);
      chk("master forces all", {high_supply_reset_n, alert_a_n, alert_b_n}, 3'h0);
      u_supervisor_partner_model.set_pin(2, 1'b1);
      u_supervisor_partner_model.set_pin(1, 1'b1);
      count_low(0, n);
      chk("master stretch", in_window(n, BTN_QUAL_CYC + D_GND), 1'b1);
      count_low(1, n);
      // Chained reset: low reset follows the high one
      u_supervisor_partner_model.chain_en = 1'b1;
      u_supervisor_partner_model.set_pin(3, 1'b0);
      repeat (900) @(negedge sys_clk);
      u_supervisor_partner_model.set_pin(3, 1'b1);
      count_low(0, n);
      chk("chained low held", low_supply_reset_n, 1'b0);
      count_low(1, n);
      chk("chained stretch", in_window(n, D_FLT), 1'b1);
      // Sense dip raises one alert pulse
      sense_a = 1'b1;
      repeat (100) @(negedge sys_clk);
      chk("alert on", alert_a_n, 1'b0);
      sense_a = 1'b0;
      repeat (350) @(negedge sys_clk);
      chk("alert held", alert_a_n, 1'b0);
      repeat (150) @(negedge sys_clk);
      chk("alert ends", alert_a_n, 1'b1);
      // Watchdog kicked at random spacing past any old pulse, then left to expire
      repeat (140) begin
         repeat (30 + ($unsigned($random(seed)) % 15)) @(negedge sys_clk);
         strobe = ~strobe;
      end
      chk("watchdog kicked", wd_n, 1'b1);
      repeat (45) @(negedge sys_clk);
      chk("watchdog not early", wd_n, 1'b1);
      repeat (55) @(negedge sys_clk);
      chk("watchdog expired", wd_n, 1'b0);
      test_done();
   end
endmodule
